// ===== include/rmc_pkg.sv
// Notes on behaviour
// - Peer wrote module pins: send notice, start byte 0x02, code 0xA9, one block per pin; the code sends at most 16 blocks, later pins are dropped.
// - Only successfully updated or configured pins get a block; failed ones are skipped.
// - Peer-write notice blocks use the three-byte pin read answer layout.
// - Remote pins written by remote host: notice code 0xA6, pin read answer blocks.
// - Peer configured pins: notice 0xA8, block is 0x03, pin id, function, value.
// - Length field counts only payload bytes; two three-byte blocks give six.
// - Error state: notice 0xA2, length one, status byte; 0x01 is serial fault.
// - Receive overflow aborts transmit and receive, restarts serial logic, then reports fault.
// - Each answer code is its request code plus 0x40.
// - Control requests: reset 0x00, state query 0x01, sleep 0x02.
// - Maintenance requests: serial off 0x1B, defaults restore 0x1C, bootloader 0x1F.
// - Link requests: connect 0x06, close 0x07; scan 0x09, 0x0A, list 0x0B.
// - Data to peer uses 0x04; scan reply fill uses 0x0C.
// - Pairing requests: key reply 0x0D, erase 0x0E, paired list 0x0F.
// - Key compare reply 0x24; unpaired admit 0x2D.
// - Setting read 0x10, setting write 0x11.
// - Radio requests: layer change 0x1A, test enable 0x1D, test run 0x1E.
// - Own pin requests: setup 0x25, write 0x26, read 0x27, setup query 0x2B.
// - Peer pin requests: setup 0x28, write 0x29, read 0x2A, setup query 0x2C.
// - Setting read answers with 0x50; detected list answers with 0x4B.
// - Multi-byte fields, the frame length too, go least significant byte first.
// - Pin value: 0x00 low, 0x01 high, 0xFF failed; ratio 0x00 to 0xFE.
// - First byte of each pin block counts the bytes that follow in it.
package rmc_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ      = 200_000_000;
	localparam int unsigned SERIAL_BAUD = 2_000_000;
	localparam int unsigned BIT_CYC     = CLK_HZ / SERIAL_BAUD;
	localparam logic [10:0] BIT_CNT_MAX = 11'(BIT_CYC - 1);
	localparam logic [10:0] HALF_CNT    = 11'(BIT_CYC / 2);

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam logic [7:0]  START_BYTE   = 8'h02;
	localparam logic [7:0]  ANSWER_FLAG  = 8'h40;
	localparam logic [15:0] FAULT_LEN    = 16'h0001;
	localparam logic [7:0]  STATUS_SERIAL_FAULT = 8'h01;
	localparam logic [7:0]  PIN_RD_BLK_LEN  = 8'h02;
	localparam logic [7:0]  PIN_CFG_BLK_LEN = 8'h03;
	localparam logic [7:0]  PIN_VAL_LOW  = 8'h00;
	localparam logic [7:0]  PIN_VAL_HIGH = 8'h01;
	localparam logic [7:0]  PIN_VAL_FAIL = 8'hff;
	localparam logic [7:0]  PIN_RATIO_FULL = 8'hfe;

	// ------------------------------------------------------------
	// Notice codes
	// ------------------------------------------------------------
	localparam logic [7:0] FAULT_NOTICE                = 8'ha2;
	localparam logic [7:0] REMOTE_HOST_PIN_WRITE_NOTICE = 8'ha6;
	localparam logic [7:0] PEER_PIN_CONFIG_NOTICE      = 8'ha8;
	localparam logic [7:0] PEER_PIN_WRITE_NOTICE       = 8'ha9;

	// Pin notice kinds on the firmware port
	localparam logic [1:0] PK_PEER_WRITE = 2'h0;
	localparam logic [1:0] PK_HOST_WRITE = 2'h1;
	localparam logic [1:0] PK_PEER_CFG   = 2'h2;

	// ------------------------------------------------------------
	// Request codes
	// ------------------------------------------------------------
	localparam logic [7:0] RESET_REQUEST            = 8'h00;
	localparam logic [7:0] STATE_QUERY_REQUEST      = 8'h01;
	localparam logic [7:0] SLEEP_REQUEST            = 8'h02;
	localparam logic [7:0] DATA_SEND_REQUEST        = 8'h04;
	localparam logic [7:0] CONNECT_REQUEST          = 8'h06;
	localparam logic [7:0] LINK_CLOSE_REQUEST       = 8'h07;
	localparam logic [7:0] SCAN_BEGIN_REQUEST       = 8'h09;
	localparam logic [7:0] SCAN_END_REQUEST         = 8'h0a;
	localparam logic [7:0] DETECTED_LIST_REQUEST    = 8'h0b;
	localparam logic [7:0] SCAN_REPLY_FILL_REQUEST  = 8'h0c;
	localparam logic [7:0] PAIRING_KEY_REPLY        = 8'h0d;
	localparam logic [7:0] PAIRING_ERASE_REQUEST    = 8'h0e;
	localparam logic [7:0] PAIRED_LIST_REQUEST      = 8'h0f;
	localparam logic [7:0] SETTING_READ_REQUEST     = 8'h10;
	localparam logic [7:0] SETTING_WRITE_REQUEST    = 8'h11;
	localparam logic [7:0] RADIO_LAYER_CHANGE_REQUEST = 8'h1a;
	localparam logic [7:0] SERIAL_OFF_REQUEST       = 8'h1b;
	localparam logic [7:0] DEFAULTS_RESTORE_REQUEST = 8'h1c;
	localparam logic [7:0] RADIO_TEST_ENABLE_REQUEST = 8'h1d;
	localparam logic [7:0] RADIO_TEST_RUN_REQUEST   = 8'h1e;
	localparam logic [7:0] BOOTLOADER_REQUEST       = 8'h1f;
	localparam logic [7:0] KEY_COMPARE_REPLY        = 8'h24;
	localparam logic [7:0] OWN_PIN_SETUP_REQUEST    = 8'h25;
	localparam logic [7:0] OWN_PIN_WRITE_REQUEST    = 8'h26;
	localparam logic [7:0] OWN_PIN_READ_REQUEST     = 8'h27;
	localparam logic [7:0] PEER_PIN_SETUP_REQUEST   = 8'h28;
	localparam logic [7:0] PEER_PIN_WRITE_REQUEST   = 8'h29;
	localparam logic [7:0] PEER_PIN_READ_REQUEST    = 8'h2a;
	localparam logic [7:0] OWN_PIN_SETUP_QUERY      = 8'h2b;
	localparam logic [7:0] PEER_PIN_SETUP_QUERY     = 8'h2c;
	localparam logic [7:0] UNPAIRED_ADMIT_REQUEST   = 8'h2d;

	// ------------------------------------------------------------
	// Buffering
	// ------------------------------------------------------------
	localparam int unsigned RX_FIFO_WIDTH = 8;
	localparam int unsigned RX_FIFO_DEPTH = 32;
	localparam int unsigned PIN_SLOTS     = 16;
	localparam logic [4:0]  PIN_SLOTS_CNT = 5'h10;

	typedef enum logic [2:0] {
		RMC_P_HUNT = 3'b000,
		RMC_P_CMD  = 3'b001,
		RMC_P_LENL = 3'b010,
		RMC_P_LENH = 3'b011,
		RMC_P_PAY  = 3'b100,
		RMC_P_CHK  = 3'b101
	} rmc_parse_e;

	typedef enum logic [2:0] {
		RMC_T_IDLE = 3'b000,
		RMC_T_CMD  = 3'b001,
		RMC_T_LENL = 3'b010,
		RMC_T_LENH = 3'b011,
		RMC_T_PAY  = 3'b100,
		RMC_T_CHK  = 3'b101
	} rmc_tx_e;

	typedef enum logic [1:0] {
		RMC_SRC_FAULT = 2'b00,
		RMC_SRC_ANS   = 2'b01,
		RMC_SRC_PIN   = 2'b10
	} rmc_src_e;

	function automatic logic rmc_is_request(input logic [7:0] c);
		case (c)
			RESET_REQUEST, STATE_QUERY_REQUEST, SLEEP_REQUEST,
			SERIAL_OFF_REQUEST, DEFAULTS_RESTORE_REQUEST, BOOTLOADER_REQUEST,
			CONNECT_REQUEST, LINK_CLOSE_REQUEST, SCAN_BEGIN_REQUEST, SCAN_END_REQUEST,
			DETECTED_LIST_REQUEST, DATA_SEND_REQUEST, SCAN_REPLY_FILL_REQUEST,
			PAIRING_KEY_REPLY, PAIRING_ERASE_REQUEST, PAIRED_LIST_REQUEST,
			KEY_COMPARE_REPLY, UNPAIRED_ADMIT_REQUEST,
			SETTING_READ_REQUEST, SETTING_WRITE_REQUEST,
			RADIO_LAYER_CHANGE_REQUEST, RADIO_TEST_ENABLE_REQUEST, RADIO_TEST_RUN_REQUEST,
			OWN_PIN_SETUP_REQUEST, OWN_PIN_WRITE_REQUEST, OWN_PIN_READ_REQUEST, OWN_PIN_SETUP_QUERY,
			PEER_PIN_SETUP_REQUEST, PEER_PIN_WRITE_REQUEST, PEER_PIN_READ_REQUEST,
			PEER_PIN_SETUP_QUERY: rmc_is_request = 1'b1;
			default: rmc_is_request = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] rmc_notice_code(input logic [1:0] kind);
		case (kind)
			PK_HOST_WRITE: rmc_notice_code = REMOTE_HOST_PIN_WRITE_NOTICE;
			PK_PEER_CFG:   rmc_notice_code = PEER_PIN_CONFIG_NOTICE;
			default:       rmc_notice_code = PEER_PIN_WRITE_NOTICE;
		endcase
	endfunction

endpackage

// ===== verilog/rmc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module rmc_fifo
	import rmc_pkg::*;
#(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             mclk,
	input  wire logic             reset_n,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_r;
	logic [AW:0]      rd_ptr_r;
	logic             push;
	logic             pop;

	// Extra pointer bit tells full from empty
	assign in_ready  = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]) || (wr_ptr_r[AW] == rd_ptr_r[AW]);
	assign out_valid = (wr_ptr_r != rd_ptr_r);
	assign out_data  = mem[rd_ptr_r[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n || flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// ===== verilog/rmc_codec.sv
`timescale 1ns/100ps
`default_nettype none
module rmc_codec
	import rmc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        uart_rxd,
	output logic             uart_txd,
	output logic             rq_hdr,
	output logic [7:0]       rq_cmd,
	output logic [15:0]      rq_len,
	output logic             rq_known,
	output logic             rq_data_valid,
	output logic [7:0]       rq_data,
	input  wire logic        rq_data_ready,
	output logic             rq_done,
	output logic             rq_good,
	input  wire logic        ans_start,
	input  wire logic [7:0]  ans_req,
	input  wire logic [15:0] ans_len,
	output logic             ans_busy,
	input  wire logic        ans_byte_valid,
	input  wire logic [7:0]  ans_byte,
	output logic             ans_byte_ready,
	input  wire logic        pin_valid,
	output logic             pin_ready,
	input  wire logic [1:0]  pin_kind,
	input  wire logic [7:0]  pin_id,
	input  wire logic [7:0]  pin_func,
	input  wire logic [7:0]  pin_value,
	input  wire logic        pin_ok,
	input  wire logic        pin_last,
	output logic             serial_fault
);

	// ------------------------------------------------------------
	// Serial receive
	// ------------------------------------------------------------
	logic        rxd_s1_r;
	logic        rxd_s2_r;
	logic        rx_act_r;
	logic [10:0] rx_div_r;
	logic [3:0]  rx_bit_r;
	logic [7:0]  rx_sh_r;
	logic        rx_done_r;
	logic        restart_r;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        fifo_out_ready;
	logic [7:0]  fifo_out_data;
	logic        overflow;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rxd_s1_r <= 1'b1;
			rxd_s2_r <= 1'b1;
		end else begin
			rxd_s1_r <= uart_rxd;
			rxd_s2_r <= rxd_s1_r;
		end
	end

	// Start bit is checked again at mid-bit so a glitch is not taken as a byte
	always_ff @(posedge mclk) begin
		if (!reset_n || restart_r) begin
			rx_act_r  <= 1'b0;
			rx_div_r  <= '0;
			rx_bit_r  <= '0;
			rx_sh_r   <= '0;
			rx_done_r <= 1'b0;
		end else begin
			rx_done_r <= 1'b0;
			if (!rx_act_r) begin
				if (!rxd_s2_r) begin
					rx_act_r <= 1'b1;
					rx_div_r <= HALF_CNT;
					rx_bit_r <= '0;
				end
			end else if (rx_div_r != '0) begin
				rx_div_r <= rx_div_r - 1'b1;
			end else begin
				rx_div_r <= BIT_CNT_MAX;
				rx_bit_r <= rx_bit_r + 1'b1;
				if (rx_bit_r == 4'h0) begin
					rx_act_r <= !rxd_s2_r;
				end else if (rx_bit_r == 4'h9) begin
					rx_act_r  <= 1'b0;
					rx_done_r <= rxd_s2_r;
				end else begin
					rx_sh_r <= {rxd_s2_r, rx_sh_r[7:1]};
				end
			end
		end
	end

	// The serial link cannot be stalled, so a full buffer is an overrun
	assign overflow = rx_done_r && !fifo_in_ready;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			restart_r    <= 1'b0;
			serial_fault <= 1'b0;
		end else begin
			restart_r    <= overflow;
			serial_fault <= overflow;
		end
	end

	rmc_fifo #(
		.WIDTH (RX_FIFO_WIDTH),
		.DEPTH (RX_FIFO_DEPTH)
	) u_rx_fifo (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.flush     (restart_r),
		.in_valid  (rx_done_r),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_sh_r),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// ------------------------------------------------------------
	// Request parser
	// ------------------------------------------------------------
	rmc_parse_e  pst_r;
	logic [7:0]  p_sum_r;
	logic [7:0]  p_lenl_r;
	logic [15:0] p_cnt_r;
	logic        p_take;

	// A held payload byte stalls the parser; the buffer absorbs the wait
	assign fifo_out_ready = !restart_r && ((pst_r != RMC_P_PAY) || !rq_data_valid);
	assign p_take         = fifo_out_valid && fifo_out_ready;

	always_ff @(posedge mclk) begin
		if (!reset_n || restart_r) begin
			pst_r         <= RMC_P_HUNT;
			p_sum_r       <= '0;
			p_lenl_r      <= '0;
			p_cnt_r       <= '0;
			rq_hdr        <= 1'b0;
			rq_cmd        <= '0;
			rq_len        <= '0;
			rq_known      <= 1'b0;
			rq_data_valid <= 1'b0;
			rq_data       <= '0;
			rq_done       <= 1'b0;
			rq_good       <= 1'b0;
		end else begin
			rq_hdr  <= 1'b0;
			rq_done <= 1'b0;
			if (rq_data_valid && rq_data_ready) begin
				rq_data_valid <= 1'b0;
			end
			if (p_take) begin
				p_sum_r <= p_sum_r ^ fifo_out_data;
				case (pst_r)
					RMC_P_HUNT: begin
						p_sum_r <= START_BYTE;
						if (fifo_out_data == START_BYTE) begin
							pst_r <= RMC_P_CMD;
						end
					end
					RMC_P_CMD: begin
						rq_cmd   <= fifo_out_data;
						rq_known <= rmc_is_request(fifo_out_data);
						pst_r    <= RMC_P_LENL;
					end
					RMC_P_LENL: begin
						p_lenl_r <= fifo_out_data;
						pst_r    <= RMC_P_LENH;
					end
					RMC_P_LENH: begin
						rq_len  <= {fifo_out_data, p_lenl_r};
						p_cnt_r <= {fifo_out_data, p_lenl_r};
						rq_hdr  <= 1'b1;
						pst_r   <= ({fifo_out_data, p_lenl_r} == 16'h0000) ? RMC_P_CHK : RMC_P_PAY;
					end
					RMC_P_PAY: begin
						rq_data_valid <= 1'b1;
						rq_data       <= fifo_out_data;
						p_cnt_r       <= p_cnt_r - 1'b1;
						if (p_cnt_r == 16'h0001) begin
							pst_r <= RMC_P_CHK;
						end
					end
					RMC_P_CHK: begin
						rq_done <= 1'b1;
						rq_good <= (fifo_out_data == p_sum_r);
						pst_r   <= RMC_P_HUNT;
					end
					default: pst_r <= RMC_P_HUNT;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Pin notice collection
	// ------------------------------------------------------------
	logic [7:0] pin_id_m  [PIN_SLOTS];
	logic [7:0] pin_fn_m  [PIN_SLOTS];
	logic [7:0] pin_val_m [PIN_SLOTS];
	logic [4:0] pin_cnt_r;
	logic [1:0] pin_kind_r;
	logic       pin_pend_r;
	logic       pin_acc;
	logic       pin_store;
	logic       pin_sent;

	assign pin_acc   = pin_valid && pin_ready;
	assign pin_store = pin_acc && pin_ok && (pin_cnt_r != PIN_SLOTS_CNT);

	always_ff @(posedge mclk) begin
		if (pin_store) begin
			pin_id_m[pin_cnt_r[3:0]]  <= pin_id;
			pin_fn_m[pin_cnt_r[3:0]]  <= pin_func;
			pin_val_m[pin_cnt_r[3:0]] <= pin_value;
		end
	end

	// Notice with no successful pin is dropped instead of sent empty
	always_ff @(posedge mclk) begin
		if (!reset_n || restart_r || pin_sent) begin
			pin_cnt_r  <= '0;
			pin_pend_r <= 1'b0;
			pin_ready  <= 1'b1;
			if (!reset_n) begin
				pin_kind_r <= PK_PEER_WRITE;
			end
		end else if (pin_acc) begin
			pin_kind_r <= pin_kind;
			if (pin_last) begin
				if (pin_store || (pin_cnt_r != '0)) begin
					pin_pend_r <= 1'b1;
					pin_ready  <= 1'b0;
					pin_cnt_r  <= pin_cnt_r + {4'h0, pin_store};
				end else begin
					pin_cnt_r <= '0;
				end
			end else begin
				pin_cnt_r <= pin_cnt_r + {4'h0, pin_store};
			end
		end
	end

	// ------------------------------------------------------------
	// Answer and fault requests
	// ------------------------------------------------------------
	logic        fault_pend_r;
	logic        ans_pend_r;
	logic [7:0]  ans_req_r;
	logic [15:0] ans_len_r;
	logic        tx_go;
	logic        fault_take;
	logic        ans_take;
	logic        ans_sent;
	rmc_tx_e     tst_r;
	rmc_src_e    src_r;

	assign fault_take = tx_go && (tst_r == RMC_T_IDLE) && fault_pend_r;
	assign ans_take   = tx_go && (tst_r == RMC_T_IDLE) && !fault_pend_r && ans_pend_r;
	assign ans_sent   = tx_go && (tst_r == RMC_T_CHK) && (src_r == RMC_SRC_ANS);
	assign pin_sent   = tx_go && (tst_r == RMC_T_CHK) && (src_r == RMC_SRC_PIN);

	// New overrun wins over the clearing take in the same cycle
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			fault_pend_r <= 1'b0;
		end else if (overflow) begin
			fault_pend_r <= 1'b1;
		end else if (fault_take) begin
			fault_pend_r <= 1'b0;
		end
	end

	// Start while busy is ignored; an overrun abandons the answer
	always_ff @(posedge mclk) begin
		if (!reset_n || restart_r) begin
			ans_pend_r <= 1'b0;
			ans_busy   <= 1'b0;
			if (!reset_n) begin
				ans_req_r <= '0;
				ans_len_r <= '0;
			end
		end else if (ans_start && !ans_busy) begin
			ans_pend_r <= 1'b1;
			ans_busy   <= 1'b1;
			ans_req_r  <= ans_req;
			ans_len_r  <= ans_len;
		end else begin
			if (ans_take) begin
				ans_pend_r <= 1'b0;
			end
			if (ans_sent) begin
				ans_busy <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Frame transmitter
	// ------------------------------------------------------------
	logic [7:0]  t_cmd_r;
	logic [15:0] t_len_r;
	logic [15:0] t_cnt_r;
	logic [7:0]  t_sum_r;
	logic [3:0]  pb_idx_r;
	logic [1:0]  pb_pos_r;
	logic        ser_busy_r;
	logic [7:0]  tx_byte;
	logic [7:0]  pin_byte;
	logic        pin_cfg;
	logic [15:0] pin_n16;

	assign pin_cfg = (pin_kind_r == PK_PEER_CFG);
	assign pin_n16 = {11'h000, pin_cnt_r};

	always_comb begin
		case (pb_pos_r)
			2'h0: pin_byte = pin_cfg ? PIN_CFG_BLK_LEN : PIN_RD_BLK_LEN;
			2'h1: pin_byte = pin_id_m[pb_idx_r];
			2'h2: pin_byte = pin_cfg ? pin_fn_m[pb_idx_r] : pin_val_m[pb_idx_r];
			default: pin_byte = pin_val_m[pb_idx_r];
		endcase
	end

	always_comb begin
		tx_byte = 8'h00;
		tx_go   = 1'b0;
		case (tst_r)
			RMC_T_IDLE: begin
				tx_byte = START_BYTE;
				tx_go   = fault_pend_r || ans_pend_r || pin_pend_r;
			end
			RMC_T_CMD: begin
				tx_byte = t_cmd_r;
				tx_go   = 1'b1;
			end
			RMC_T_LENL: begin
				tx_byte = t_len_r[7:0];
				tx_go   = 1'b1;
			end
			RMC_T_LENH: begin
				tx_byte = t_len_r[15:8];
				tx_go   = 1'b1;
			end
			RMC_T_PAY: begin
				case (src_r)
					RMC_SRC_FAULT: tx_byte = STATUS_SERIAL_FAULT;
					RMC_SRC_PIN:   tx_byte = pin_byte;
					default:       tx_byte = ans_byte;
				endcase
				tx_go = (src_r != RMC_SRC_ANS) || (ans_byte_valid && ans_byte_ready);
			end
			RMC_T_CHK: begin
				tx_byte = t_sum_r;
				tx_go   = 1'b1;
			end
			default: tx_go = 1'b0;
		endcase
		tx_go = tx_go && !ser_busy_r && !restart_r;
	end

	always_ff @(posedge mclk) begin
		if (!reset_n || restart_r) begin
			tst_r          <= RMC_T_IDLE;
			src_r          <= RMC_SRC_FAULT;
			t_cmd_r        <= '0;
			t_len_r        <= '0;
			t_cnt_r        <= '0;
			t_sum_r        <= '0;
			pb_idx_r       <= '0;
			pb_pos_r       <= '0;
			ans_byte_ready <= 1'b0;
		end else begin
			ans_byte_ready <= (tst_r == RMC_T_PAY) && (src_r == RMC_SRC_ANS) && !ser_busy_r && !tx_go;
			if (tx_go) begin
				t_sum_r <= t_sum_r ^ tx_byte;
				case (tst_r)
					RMC_T_IDLE: begin
						t_sum_r  <= START_BYTE;
						pb_idx_r <= '0;
						pb_pos_r <= '0;
						tst_r    <= RMC_T_CMD;
						if (fault_pend_r) begin
							src_r   <= RMC_SRC_FAULT;
							t_cmd_r <= FAULT_NOTICE;
							t_len_r <= FAULT_LEN;
						end else if (ans_pend_r) begin
							src_r   <= RMC_SRC_ANS;
							t_cmd_r <= ans_req_r | ANSWER_FLAG;
							t_len_r <= ans_len_r;
						end else begin
							src_r   <= RMC_SRC_PIN;
							t_cmd_r <= rmc_notice_code(pin_kind_r);
							t_len_r <= pin_cfg ? (pin_n16 << 2) : ((pin_n16 << 1) + pin_n16);
						end
					end
					RMC_T_CMD:  tst_r <= RMC_T_LENL;
					RMC_T_LENL: tst_r <= RMC_T_LENH;
					RMC_T_LENH: begin
						t_cnt_r <= t_len_r;
						tst_r   <= (t_len_r == 16'h0000) ? RMC_T_CHK : RMC_T_PAY;
					end
					RMC_T_PAY: begin
						t_cnt_r <= t_cnt_r - 1'b1;
						if (pb_pos_r == (pin_cfg ? 2'h3 : 2'h2)) begin
							pb_pos_r <= '0;
							pb_idx_r <= pb_idx_r + 1'b1;
						end else begin
							pb_pos_r <= pb_pos_r + 1'b1;
						end
						if (t_cnt_r == 16'h0001) begin
							tst_r <= RMC_T_CHK;
						end
					end
					default: tst_r <= RMC_T_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Serial transmit, 8N1
	// ------------------------------------------------------------
	logic [10:0] ser_div_r;
	logic [3:0]  ser_cnt_r;
	logic [8:0]  ser_sh_r;

	// An abort drops the line high mid-byte; the host resyncs on the start byte
	always_ff @(posedge mclk) begin
		if (!reset_n || restart_r) begin
			ser_busy_r <= 1'b0;
			ser_div_r  <= '0;
			ser_cnt_r  <= '0;
			ser_sh_r   <= '1;
			uart_txd   <= 1'b1;
		end else if (tx_go) begin
			ser_busy_r <= 1'b1;
			ser_div_r  <= BIT_CNT_MAX;
			ser_cnt_r  <= '0;
			ser_sh_r   <= {1'b1, tx_byte};
			uart_txd   <= 1'b0;
		end else if (ser_busy_r) begin
			if (ser_div_r != '0) begin
				ser_div_r <= ser_div_r - 1'b1;
			end else begin
				ser_div_r <= BIT_CNT_MAX;
				if (ser_cnt_r == 4'h9) begin
					ser_busy_r <= 1'b0;
				end else begin
					uart_txd  <= ser_sh_r[0];
					ser_sh_r  <= {1'b1, ser_sh_r[8:1]};
					ser_cnt_r <= ser_cnt_r + 1'b1;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ===== bench/rmc_codec_checker.sv
`timescale 1ns/100ps
`default_nettype none
module rmc_codec_checker (
	input wire logic       mclk,
	input wire logic       reset_n,
	input wire logic       uart_txd,
	input wire logic       rq_hdr,
	input wire logic       rq_done,
	input wire logic       rq_data_valid,
	input wire logic       rq_data_ready,
	input wire logic [7:0] rq_data,
	input wire logic       ans_start,
	input wire logic       ans_busy,
	input wire logic       pin_valid,
	input wire logic       pin_ready,
	input wire logic       pin_ok,
	input wire logic       pin_last,
	input wire logic       serial_fault
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_pin_close: assert property (pin_valid && pin_ready && pin_ok && pin_last && !serial_fault |=> !pin_ready)
		else $error("pin intake stayed open");
	a_ans_accept: assert property (ans_start && !ans_busy && !serial_fault |=> ans_busy)
		else $error("answer not accepted");
	a_ans_hold: assert property ($rose(ans_busy) ##1 (!serial_fault)[*8] |-> ans_busy)
		else $error("answer busy dropped early");
	a_fault_abort: assert property (serial_fault |-> ##[0:1] (uart_txd && !ans_busy))
		else $error("transmit not aborted");
	a_fault_pins: assert property (serial_fault |-> ##[0:1] pin_ready)
		else $error("pin notice not dropped");
	a_hdr_pulse: assert property (rq_hdr |=> !rq_hdr && !rq_done)
		else $error("header pulse too long");
	a_done_pulse: assert property (rq_done |=> !rq_done)
		else $error("done pulse too long");
	a_data_hold: assert property (rq_data_valid && !rq_data_ready && !serial_fault
		|=> rq_data_valid && $stable(rq_data))
		else $error("payload byte not held");
	cover property ($fell(pin_ready));
	cover property (rq_data_valid && rq_data_ready);
	cover property ($rose(ans_busy));
endmodule
bind rmc_codec rmc_codec_checker u_chk (.mclk, .reset_n, .uart_txd, .rq_hdr, .rq_done, .rq_data_valid,
	.rq_data_ready, .rq_data, .ans_start, .ans_busy, .pin_valid, .pin_ready, .pin_ok, .pin_last, .serial_fault);
`default_nettype wire

// ===== bench/rmc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module rmc_host_model
	import rmc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       line_in,
	output var  logic       line_out,
	output var  logic       got,
	output var  logic [7:0] got_byte
);
	initial begin
		line_out = 1'b1;
		got = 1'b0;
		got_byte = 8'h00;
	end
	// Request bytes go out 8N1, least significant bit first
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			line_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (BIT_CYC) @(posedge mclk);
		end
	endtask
	// Receive never answers a notice, it only hands bytes on
	always begin
		@(negedge line_in);
		repeat (BIT_CYC / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge mclk);
			got_byte[i] = line_in;
		end
		repeat (BIT_CYC) @(posedge mclk);
		got <= 1'b1;
		@(posedge mclk);
		got <= 1'b0;
	end
endmodule
`default_nettype wire

// ===== bench/rmc_codec_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rmc_codec_bench import rmc_pkg::*; ;
	logic        mclk = 1'b0, reset_n = 1'b0, rq_data_ready = 1'b0, ans_start = 1'b0;
	logic        pin_valid = 1'b0, pin_ok = 1'b0, pin_last = 1'b0, ans_byte_valid = 1'b0, hold = 1'b0;
	logic [1:0]  pin_kind = 2'h0;
	logic [7:0]  ans_req = 8'h00, ans_byte = 8'h00, pin_id = 8'h00, pin_value = 8'h00, rx_byte, rq_cmd, rq_data;
	logic [7:0]  id, val, c, p;
	logic [15:0] ans_len = 16'h0000, rq_len;
	logic        uart_rxd, uart_txd, rx_got, rq_hdr, rq_known, rq_data_valid, rq_done, rq_good;
	logic        ans_busy, ans_byte_ready, pin_ready, serial_fault;
	logic [7:0]  exp_tx[$], exp_rq[$], fr[$];
	logic [7:0]  codes[4] = '{STATE_QUERY_REQUEST, LINK_CLOSE_REQUEST, SETTING_READ_REQUEST, PEER_PIN_READ_REQUEST};
	int          failures = 0, samples_checked = 0;

	rmc_codec dut (.mclk, .reset_n, .uart_rxd, .uart_txd, .rq_hdr, .rq_cmd, .rq_len, .rq_known, .rq_data_valid,
		.rq_data, .rq_data_ready, .rq_done, .rq_good, .ans_start, .ans_req, .ans_len, .ans_busy,
		.ans_byte_valid, .ans_byte, .ans_byte_ready, .pin_valid, .pin_ready, .pin_kind, .pin_id,
		.pin_func(8'h00), .pin_value, .pin_ok, .pin_last, .serial_fault);
	rmc_host_model host (.mclk, .line_in(uart_txd), .line_out(uart_rxd), .got(rx_got), .got_byte(rx_byte));

	always #2.5 mclk = ~mclk;
	always @(posedge mclk) rq_data_ready <= !hold && 1'($urandom);

	task cmp8(input logic [7:0] a, input logic [7:0] e);
		samples_checked++;
		if (a !== e) begin
			failures++;
			$display("[FAIL] t=%0t got %h exp %h", $time, a, e);
		end
	endtask

	task complete_run;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task drain(input string t);
		for (int n = 0; n < 60000 && exp_tx.size() + exp_rq.size() > 0; n++) @(posedge mclk);
		if (exp_tx.size() + exp_rq.size() > 0) failures++;
		$display("test %s ended", t);
	endtask

	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(posedge mclk) begin
		if (rx_got) cmp8(rx_byte, exp_tx.pop_front());
		if (rq_hdr) begin
			cmp8(rq_cmd, exp_rq.pop_front());
			cmp8({rq_known, rq_len[6:0]}, exp_rq.pop_front());
		end
		if (rq_data_valid && rq_data_ready) cmp8(rq_data, exp_rq.pop_front());
		if (rq_done) cmp8({7'h00, rq_good}, exp_rq.pop_front());
		if (serial_fault) cmp8({7'h00, serial_fault}, exp_rq.pop_front());
	end

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		void'($urandom(32'hb9df7b56));
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		id = 8'($urandom);
		val = {7'h00, 1'($urandom)};
		c = codes[$urandom % 4];
		p = 8'($urandom);
		// Failed pin leaves no block, so one block and length three
		exp_tx = '{START_BYTE, REMOTE_HOST_PIN_WRITE_NOTICE, 8'h03, 8'h00, PIN_RD_BLK_LEN, id, val,
			START_BYTE ^ REMOTE_HOST_PIN_WRITE_NOTICE ^ 8'h03 ^ PIN_RD_BLK_LEN ^ id ^ val,
			START_BYTE, c + 8'h40, 8'h01, 8'h00, p, START_BYTE ^ (c + 8'h40) ^ 8'h01 ^ p};
		exp_rq = '{c, 8'h81, p, 8'h01};
		fr = '{START_BYTE, c, 8'h01, 8'h00, p, START_BYTE ^ c ^ 8'h01 ^ p};
		fork
			foreach (fr[i]) host.send(fr[i]);
		join_none
		@(posedge mclk);
		pin_valid <= 1'b1;
		pin_kind <= PK_HOST_WRITE;
		pin_id <= ~id;
		pin_value <= PIN_VAL_FAIL;
		@(posedge mclk);
		pin_id <= id;
		pin_value <= val;
		pin_ok <= 1'b1;
		pin_last <= 1'b1;
		@(posedge mclk);
		pin_valid <= 1'b0;
		repeat (200) @(posedge mclk);
		ans_req <= c;
		ans_len <= 16'h0001;
		ans_byte <= p;
		ans_byte_valid <= 1'b1;
		ans_start <= 1'b1;
		@(posedge mclk);
		ans_start <= 1'b0;
		@(posedge mclk);
		cmp8({7'h00, ans_busy}, 8'h01);
		drain("notice and request");
		if (failures == 0) begin
			// 34th payload byte overruns; the notice is the host's cue to reset on lasting trouble
			hold <= 1'b1;
			exp_rq = '{c, 8'hc0, 8'h01};
			exp_tx = '{START_BYTE, FAULT_NOTICE, 8'h01, 8'h00, STATUS_SERIAL_FAULT,
				START_BYTE ^ FAULT_NOTICE ^ 8'h01 ^ STATUS_SERIAL_FAULT};
			fr = '{START_BYTE, c, 8'h40, 8'h00};
			fork
				begin
					foreach (fr[i]) host.send(fr[i]);
					repeat (34) host.send(8'h00);
				end
			join_none
			drain("overrun");
		end
		complete_run();
	end
endmodule
`default_nettype wire
